// ==== rtl/gpio_ports.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "gpio_ports_cfg.svh"
module gpio_ports (
  input  wire logic                        mclk_i,
  input  wire logic                        rst_n_i,
  input  wire gpio_ports_pkg::cpu_req_type req_i,
  input  wire logic                        single_port_pin_i,
  input  wire logic [5:0]                  six_bit_port_pin_i,
  input  wire logic                        dir_wr_i,
  input  wire logic                        drive_wr_i,
  output logic      [7:0]                  rd_data_o,
  output logic                             rd_valid_o,
  output logic                             single_port_pin_o,
  output logic                             single_port_pin_oe_o,
  output gpio_ports_pkg::pin_drive_type    six_bit_port_o,
  output logic                             ext_int_edge_o
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    gpio_ports_pkg::cyc_type cyc;
    logic                    rd_latch;
    logic                    sel_six;
    logic [7:0]              wr_data;
    logic                    single_latch;
    logic [5:0]              six_latch;
    logic [5:0]              six_dir;
    logic [5:0]              six_drive;
    logic                    single_pin_q;
    logic [7:0]              rd_data;
    logic                    rd_valid;
    logic                    int_edge;
    logic                    single_pin;
    logic                    single_oe;
    gpio_ports_pkg::pin_drive_type six_pins;
  } port_state_type;

  port_state_type state_ff;
  port_state_type nxt_state;
  logic [6:0]     pins_sync;

  pin_sync u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({single_port_pin_i, six_bit_port_pin_i}),
    .sync_o  (pins_sync)
  );

  // per bit: input bits read pin, output bits read latch or pin by class
  function automatic logic [5:0] six_read(input logic [5:0] lat,
                                          input logic [5:0] dir,
                                          input logic [5:0] pin,
                                          input logic       use_latch);
    six_read = use_latch ? ((lat & dir) | (pin & ~dir)) : pin;
  endfunction

  // open drain drive low only; high level left to the pull-up
  function automatic logic drive_oe(input logic lat, input logic dir,
                                    input logic od);
    drive_oe = dir & (od ? ~lat : 1'b1);
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_state          = state_ff;
    nxt_state.rd_valid = 1'b0;
    nxt_state.int_edge = 1'b0;
    unique case (state_ff.cyc)
      gpio_ports_pkg::CYC_IDLE: begin
        if (req_i.rd_req) begin
          nxt_state.cyc      = gpio_ports_pkg::CYC_READ;
          nxt_state.rd_latch = req_i.rd_latch;
          nxt_state.sel_six  = req_i.sel_six;
        end else if (req_i.wr_req) begin
          nxt_state.cyc     = gpio_ports_pkg::CYC_WRITE;
          nxt_state.sel_six = req_i.sel_six;
          nxt_state.wr_data = req_i.wr_data;
        end
      end
      gpio_ports_pkg::CYC_READ: begin
        // input sampled in read state, no holding latch on inputs
        nxt_state.cyc      = gpio_ports_pkg::CYC_IDLE;
        nxt_state.rd_valid = 1'b1;
        if (state_ff.sel_six) begin
          nxt_state.rd_data = {2'h0, six_read(state_ff.six_latch,
                              state_ff.six_dir, pins_sync[5:0],
                              state_ff.rd_latch)};
        end else begin
          nxt_state.rd_data = {`UNDEF_FILL,
                               state_ff.rd_latch ? state_ff.single_latch
                                                 : pins_sync[6]};
        end
      end
      gpio_ports_pkg::CYC_WRITE: begin
        nxt_state.cyc = gpio_ports_pkg::CYC_IDLE;
        if (state_ff.sel_six) begin
          nxt_state.six_latch = state_ff.wr_data[5:0];
        end else begin
          nxt_state.single_latch = state_ff.wr_data[0];
        end
      end
      default: begin
        nxt_state.cyc = gpio_ports_pkg::CYC_IDLE;
      end
    endcase
    // write-only config registers, single edge
    if (dir_wr_i) begin
      nxt_state.six_dir = req_i.wr_data[5:0];
    end
    if (drive_wr_i) begin
      nxt_state.six_drive = req_i.wr_data[5:0];
    end
    // edge seen on pin even when device drives it
    nxt_state.single_pin_q = pins_sync[6];
    nxt_state.int_edge     = state_ff.single_pin_q & ~pins_sync[6];
    // pin drive registered from next latch values
    nxt_state.single_pin = 1'b0;
    nxt_state.single_oe  = ~nxt_state.single_latch;
    for (int i = 0; i < `SIX_WIDTH; i++) begin
      nxt_state.six_pins.out[i] = nxt_state.six_latch[i];
      nxt_state.six_pins.oe[i]  = drive_oe(nxt_state.six_latch[i],
                                           nxt_state.six_dir[i],
                                           nxt_state.six_drive[i]);
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff              <= '0;
      state_ff.single_latch <= `SINGLE_LATCH_RST;
      state_ff.six_latch    <= `SIX_LATCH_RST;
      state_ff.six_dir      <= `SIX_DIR_RST;
      state_ff.six_drive    <= `SIX_DRIVE_RST;
      state_ff.single_pin_q <= `SYNC_RST;
      // pin outputs mirror the latches from the start, no low glitch
      state_ff.six_pins.out <= `SIX_LATCH_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data_o            = state_ff.rd_data;
  assign rd_valid_o           = state_ff.rd_valid;
  assign single_port_pin_o    = state_ff.single_pin;
  assign single_port_pin_oe_o = state_ff.single_oe;
  assign six_bit_port_o       = state_ff.six_pins;
  assign ext_int_edge_o       = state_ff.int_edge;

  // ************************************************************
  // checks
  // ************************************************************
  latch_write_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    state_ff.cyc == gpio_ports_pkg::CYC_WRITE && state_ff.sel_six
    |=> six_bit_port_o.out == $past(state_ff.wr_data[5:0]))
    else $error("six-bit latch not updated by write");
  latch_hold_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    state_ff.cyc != gpio_ports_pkg::CYC_WRITE
    |=> $stable(state_ff.six_latch) && $stable(state_ff.single_latch))
    else $error("latch changed without write");
  read_timing_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    req_i.rd_req && state_ff.cyc == gpio_ports_pkg::CYC_IDLE
    |=> ##1 rd_valid_o)
    else $error("read answer late");
  latch_read_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    state_ff.cyc == gpio_ports_pkg::CYC_READ && state_ff.rd_latch &&
    !state_ff.sel_six |=> rd_data_o[0] == $past(state_ff.single_latch))
    else $error("latch-class read wrong");
  single_upper_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    rd_valid_o && !$past(state_ff.sel_six) |-> rd_data_o[7:1] == 7'h7F)
    else $error("single-bit upper bits wrong");
  input_oe_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ##1 (six_bit_port_o.oe & ~$past(state_ff.six_dir) &
    ~$past(nxt_state.six_dir)) == 6'h00)
    else $error("input bit driven");
  edge_detect_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $fell(pins_sync[6]) |=> ext_int_edge_o)
    else $error("falling edge missed");
  reset_value_a: assert property (
    @(posedge mclk_i)
    $rose(rst_n_i) |-> state_ff.six_dir == 6'h00 &&
    state_ff.six_latch == 6'h3F && state_ff.single_latch)
    else $error("reset values wrong");
  // answer pulse stands one cycle only, requests are two apart
  valid_pulse_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    rd_valid_o |=> !rd_valid_o)
    else $error("read answer held too long");
  pin_read_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    state_ff.cyc == gpio_ports_pkg::CYC_READ && state_ff.sel_six &&
    !state_ff.rd_latch |=> rd_data_o[5:0] == $past(pins_sync[5:0]))
    else $error("pin-class read wrong");
  input_read_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    state_ff.cyc == gpio_ports_pkg::CYC_READ && state_ff.sel_six
    |=> ((rd_data_o[5:0] ^ $past(pins_sync[5:0])) &
    ~$past(state_ff.six_dir)) == 6'h00)
    else $error("input bit read from latch");
  latch_drive_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    six_bit_port_o.out == state_ff.six_latch &&
    single_port_pin_oe_o == !state_ff.single_latch)
    else $error("pin drive differs from latch");
  od_high_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (six_bit_port_o.oe & six_bit_port_o.out & state_ff.six_drive) == 6'h00)
    else $error("open-drain bit driven high");
  edge_pulse_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ext_int_edge_o |-> $past(pins_sync[6], 2) && !$past(pins_sync[6]))
    else $error("edge pulse without falling edge");
endmodule // gpio_ports
`default_nettype wire

// ==== rtl/gpio_ports_cfg.svh ====
// Summary of operation
// - each drivable bit keeps its value in an output latch until rewritten
// - inputs are not latched; source holds data or software resamples
// - pins sampled in read state one, outputs change in write state two
// - read-modify-write class reads return latch except on six-bit input bits, all others return pin
// - single-bit port latch resets to one
// - falling edge on driven single-bit pin still sets interrupt latch
// - single-bit port read gives meaningful data only in bit zero
// - six-bit port, each bit individually input or output
// - direction bit zero means input, one means output
// - direction register clears to zero on reset, all inputs
// - six-bit port latches reset to one
// - data writes update latch regardless of direction
// - serial bus pins need open-drain select, latch one, direction output
// - input bits read pin level; bit writes may overwrite input latches
`ifndef GPIO_PORTS_CFG_SVH
`define GPIO_PORTS_CFG_SVH
`define SIX_WIDTH        6
`define SINGLE_LATCH_RST 1'h1
`define SIX_LATCH_RST    6'h3F
`define SIX_DIR_RST      6'h00
`define SIX_DRIVE_RST    6'h00
`define SYNC_RST         1'h1
`define UNDEF_FILL       7'h7F
`endif

// ==== rtl/gpio_ports_pkg.sv ====
`default_nettype none
package gpio_ports_pkg;
  typedef enum logic [1:0] {
    CYC_IDLE  = 2'b00,
    CYC_READ  = 2'b01,
    CYC_WRITE = 2'b10
  } cyc_type;

  typedef struct packed {
    logic       rd_req;
    logic       rd_latch;
    logic       wr_req;
    logic       sel_six;
    logic [7:0] wr_data;
  } cpu_req_type;

  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
  } pin_drive_type;
endpackage
`default_nettype wire

// ==== rtl/pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "gpio_ports_cfg.svh"
module pin_sync (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic [6:0] pin_i,
  output logic      [6:0] sync_o
);
  typedef struct packed {
    logic [6:0] meta;
    logic [6:0] sync;
  } sync_state_type;

  sync_state_type state_ff;
  sync_state_type nxt_state;

  always_comb begin
    nxt_state      = state_ff;
    nxt_state.meta = pin_i;
    nxt_state.sync = state_ff.meta;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= {14{`SYNC_RST}};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_o = state_ff.sync;
endmodule // pin_sync
`default_nettype wire

// ==== test/pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_model (
  input  wire logic                          single_out_i,
  input  wire logic                          single_oe_i,
  input  wire gpio_ports_pkg::pin_drive_type six_i,
  input  wire logic                          single_ext_low_i,
  input  wire logic [5:0]                    six_ext_i,
  output logic                               single_level_o,
  output logic      [5:0]                    six_level_o
);
  // pulled-up wire: released means high, either side may sink it
  assign single_level_o = ~((single_oe_i & ~single_out_i)
                            | single_ext_low_i);
  // undriven bits show the outside source, held steady until read
  assign six_level_o = (six_i.oe & six_i.out)
                       | (~six_i.oe & six_ext_i);
endmodule // pin_model
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                          mclk_i, rst_n_i, dir_wr, drive_wr, ext_low;
  logic                          rd_valid, s_out, s_oe, s_lvl, edge_p;
  logic [5:0]                    ext_six, six_lvl;
  logic [7:0]                    rd_data, got;
  gpio_ports_pkg::cpu_req_type   req;
  gpio_ports_pkg::pin_drive_type six_o;
  int                            miscompares = 0;
  int                            comparisons = 0;
  int                            cycles = 0;

  gpio_ports gpio_ports_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req),
    .single_port_pin_i(s_lvl), .six_bit_port_pin_i(six_lvl),
    .dir_wr_i(dir_wr), .drive_wr_i(drive_wr), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .single_port_pin_o(s_out),
    .single_port_pin_oe_o(s_oe), .six_bit_port_o(six_o),
    .ext_int_edge_o(edge_p));
  pin_model pin_model_i (.single_out_i(s_out), .single_oe_i(s_oe),
    .six_i(six_o), .single_ext_low_i(ext_low), .six_ext_i(ext_six),
    .single_level_o(s_lvl), .six_level_o(six_lvl));

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic six, input logic [7:0] d);
    req.wr_req = 1'h1;
    req.sel_six = six;
    req.wr_data = d;
    tick(1);
    req.wr_req = 1'h0;
    tick(2);
  endtask

  task automatic rd(input logic six, input logic lat);
    req.rd_req = 1'h1;
    req.sel_six = six;
    req.rd_latch = lat;
    tick(1);
    req.rd_req = 1'h0;
    tick(1);
    check({7'h00, rd_valid}, 8'h01);
    got = rd_data;
    tick(1);
    check({7'h00, rd_valid}, 8'h00);
  endtask

  task automatic cfg(input logic dir, input logic [5:0] d);
    dir_wr = dir;
    drive_wr = ~dir;
    req.wr_data = {2'h0, d};
    tick(1);
    dir_wr = 1'h0;
    drive_wr = 1'h0;
    tick(4);
  endtask

  // edge pulse lags the pin by the synchroniser, so allow a few cycles
  task automatic wait_edge;
    int n;
    n = 0;
    while (edge_p !== 1'h1 && n < 8) begin
      tick(1);
      n++;
    end
    check({7'h00, edge_p}, 8'h01);
  endtask

  initial begin
    mclk_i = 1'h0;
    forever #2 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    req = '0;
    {dir_wr, drive_wr, ext_low, rst_n_i} = 4'h0;
    ext_six = 6'h15;
    tick(12);
    rst_n_i = 1'h1;
    check({2'h0, six_o.out}, 8'h3F);
    check({2'h0, six_o.oe}, 8'h00);
    check({7'h00, s_oe}, 8'h00);
    tick(3);
    rd(1'h0, 1'h1);
    check({7'h00, got[0]}, 8'h01);
    rd(1'h1, 1'h0);
    check({2'h0, got[5:0]}, 8'h15);
    wr(1'h1, 8'h2A);
    check({2'h0, six_o.out}, 8'h2A);
    check({2'h0, six_o.oe}, 8'h00);
    rd(1'h1, 1'h1);
    check({2'h0, got[5:0]}, 8'h15);
    cfg(1'h0, 6'h0F);
    cfg(1'h1, 6'h0F);
    check({2'h0, six_o.oe}, 8'h05);
    rd(1'h1, 1'h0);
    check({2'h0, got[5:0]}, 8'h10);
    rd(1'h1, 1'h1);
    check({2'h0, got[5:0]}, 8'h1A);
    cfg(1'h0, 6'h00);
    check({2'h0, six_o.oe}, 8'h0F);
    rd(1'h1, 1'h0);
    check({2'h0, got[5:0]}, 8'h1A);
    // second request inside the busy cycle must be dropped
    req.wr_req = 1'h1;
    req.wr_data = 8'h3C;
    tick(1);
    req.wr_data = 8'h00;
    tick(1);
    req.wr_req = 1'h0;
    tick(2);
    check({2'h0, six_o.out}, 8'h3C);
    rd(1'h0, 1'h0);
    check(got, 8'hFF);
    wr(1'h0, 8'h00);
    check({6'h00, s_oe, s_out}, 8'h02);
    wait_edge();
    rd(1'h0, 1'h1);
    check({7'h00, got[0]}, 8'h00);
    wr(1'h0, 8'h01);
    check({7'h00, s_oe}, 8'h00);
    tick(4);
    ext_low = 1'h1;
    wait_edge();
    tick(3);
    rd(1'h0, 1'h1);
    check({7'h00, got[0]}, 8'h01);
    rd(1'h0, 1'h0);
    check({7'h00, got[0]}, 8'h00);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
